/* File: common/urcf_pkg.sv */
package urcf_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam int CLK_HZ     = 100_000_000;
   localparam int BAUD_2400  = 2400;
   localparam int BAUD_4800  = 4800;
   localparam int BAUD_9600  = 9600;
   localparam int BAUD_19200 = 19200;
   localparam int TMR_W      = 16;

   // Bit periods rounded to the nearest clock
   localparam logic [15:0] BIT_CYC_2400  =
      16'((CLK_HZ + BAUD_2400 / 2) / BAUD_2400);
   localparam logic [15:0] BIT_CYC_4800  =
      16'((CLK_HZ + BAUD_4800 / 2) / BAUD_4800);
   localparam logic [15:0] BIT_CYC_9600  =
      16'((CLK_HZ + BAUD_9600 / 2) / BAUD_9600);
   localparam logic [15:0] BIT_CYC_19200 =
      16'((CLK_HZ + BAUD_19200 / 2) / BAUD_19200);

   ////////////////////////////////////////////////////////////////////////////
   // Receive buffer and flow control thresholds
   localparam int          BUF_DEPTH = 64;
   localparam int          BUF_AW    = 6;
   localparam int          FULL_PCT  = 85;
   localparam int          FREE_PCT  = 25;
   localparam logic [6:0]  LVL_FULL  = 7'(BUF_DEPTH);
   localparam logic [6:0]  LVL_HIGH  = 7'(BUF_DEPTH * FULL_PCT / 100);
   localparam logic [6:0]  LVL_LOW   = 7'((BUF_DEPTH * FREE_PCT + 99) / 100);

   ////////////////////////////////////////////////////////////////////////////
   // Setting switch positions
   localparam int SW_BAUD_A   = 0;
   localparam int SW_BAUD_B   = 1;
   localparam int SW_LEN7     = 2;
   localparam int SW_PAR_EN   = 3;
   localparam int SW_PAR_ODD  = 4;
   localparam int SW_STOP2    = 5;
   localparam int SW_DELIM_CR = 6;
   localparam int SW_HS_OFF   = 7;
   localparam logic [7:0] CFG_RESET = 8'h00;

   typedef enum logic [1:0] {
      URCF_B9600  = 2'b00,
      URCF_B4800  = 2'b01,
      URCF_B2400  = 2'b10,
      URCF_B19200 = 2'b11
   } urcf_baud_type;

   localparam logic [2:0] DATA_LAST_7 = 3'h6;
   localparam logic [2:0] DATA_LAST_8 = 3'h7;
   localparam logic [7:0] CHAR_CR     = 8'h0d;
   localparam logic [7:0] CHAR_LF     = 8'h0a;

   ////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [31:0] A_TXDATA  = 32'h0000_0000;
   localparam logic [31:0] A_RXDATA  = 32'h0000_0004;
   localparam logic [31:0] A_STATUS  = 32'h0000_0008;
   localparam logic [31:0] A_CONTROL = 32'h0000_000c;

   localparam int RXD_VALID_BIT = 8;
   localparam int RXD_DELIM_BIT = 9;
   localparam int ST_TX_FULL    = 0;
   localparam int ST_RX_AVAIL   = 1;
   localparam int ST_RTS        = 2;
   localparam int ST_CTS        = 3;
   localparam int ST_REMOTE     = 4;
   localparam int ST_PAR_ERR    = 5;
   localparam int ST_FRM_ERR    = 6;
   localparam int ST_OVR_ERR    = 7;
   localparam int ST_TEST_DONE  = 8;
   localparam int ST_TX_BUSY    = 9;
   localparam int ST_CFG_LSB    = 16;
   localparam int ST_LVL_LSB    = 24;
   localparam int CT_TEST_DONE  = 0;
   localparam int CT_LOCAL      = 1;
   localparam int CT_CLR_ERR    = 2;

   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      TX_IDLE  = 3'b000,
      TX_START = 3'b001,
      TX_DATA  = 3'b010,
      TX_PAR   = 3'b011,
      TX_STOP  = 3'b100
   } urcf_tx_state_type;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_START = 3'b001,
      RX_DATA  = 3'b010,
      RX_PAR   = 3'b011,
      RX_STOP  = 3'b100
   } urcf_rx_state_type;

endpackage

/* File: hw/urcf_bit_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module urcf_bit_timer (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       restart,
   input  wire logic [urcf_pkg::TMR_W-1:0] period,
   output logic                            half,
   output logic                            full
);

   logic [urcf_pkg::TMR_W-1:0] cnt;
   logic [urcf_pkg::TMR_W-1:0] next_cnt;

   // Free running; restart aligns the bit grid to a start edge
   always_comb begin
      full = !restart && (cnt == period - 16'h0001);
      half = !restart && (cnt == {1'b0, period[urcf_pkg::TMR_W-1:1]});
      if (restart || full) begin
         next_cnt = 16'h0000;
      end else begin
         next_cnt = cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt <= 16'h0000;
      end else begin
         cnt <= next_cnt;
      end
   end

endmodule
`default_nettype wire

/* File: hw/urcf_top.sv */
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module urcf_top #(
   parameter logic [15:0] BIT_CYC_2400  = urcf_pkg::BIT_CYC_2400,
   parameter logic [15:0] BIT_CYC_4800  = urcf_pkg::BIT_CYC_4800,
   parameter logic [15:0] BIT_CYC_9600  = urcf_pkg::BIT_CYC_9600,
   parameter logic [15:0] BIT_CYC_19200 = urcf_pkg::BIT_CYC_19200
) (
   input  wire logic        CLK_SYS,
   input  wire logic        RST_N,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic [7:0]  CFG_SW,
   input  wire logic        RXD,
   output logic             TXD,
   output logic             RTS,
   input  wire logic        CTS,
   output logic             REMOTE
);

   ////////////////////////////////////////////////////////////////////////////
   // Configuration, caught once after reset release
   logic        cfg_taken;
   logic        next_cfg_taken;
   logic [7:0]  cfg;
   logic [7:0]  next_cfg;
   logic        len7;
   logic        par_en;
   logic        par_odd;
   logic        stop2;
   logic        hs_off;
   logic [2:0]  data_last;
   logic [15:0] bit_cyc;
   urcf_pkg::urcf_baud_type baud_sel;

   always_comb begin
      next_cfg_taken = 1'b1;
      next_cfg       = cfg_taken ? cfg : CFG_SW;
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         cfg_taken <= 1'b0;
         cfg       <= urcf_pkg::CFG_RESET;
      end else begin
         cfg_taken <= next_cfg_taken;
         cfg       <= next_cfg;
      end
   end

   assign baud_sel  = urcf_pkg::urcf_baud_type'({cfg[urcf_pkg::SW_BAUD_A],
                                                 cfg[urcf_pkg::SW_BAUD_B]});
   assign len7      = cfg[urcf_pkg::SW_LEN7];
   assign par_en    = cfg[urcf_pkg::SW_PAR_EN];
   assign par_odd   = cfg[urcf_pkg::SW_PAR_ODD];
   assign stop2     = cfg[urcf_pkg::SW_STOP2];
   assign hs_off    = cfg[urcf_pkg::SW_HS_OFF];
   assign data_last = len7 ? urcf_pkg::DATA_LAST_7 : urcf_pkg::DATA_LAST_8;

   always_comb begin
      case (baud_sel)
         urcf_pkg::URCF_B4800:  bit_cyc = BIT_CYC_4800;
         urcf_pkg::URCF_B2400:  bit_cyc = BIT_CYC_2400;
         urcf_pkg::URCF_B19200: bit_cyc = BIT_CYC_19200;
         default:               bit_cyc = BIT_CYC_9600;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states, reads registered at the address phase
   logic        take;
   logic        dp_write;
   logic        next_dp_write;
   logic [31:0] dp_addr;
   logic [31:0] next_dp_addr;
   logic [31:0] rd_mux;
   logic [31:0] next_hrdata;
   logic        rd_pop;
   logic        wr_tx;
   logic        wr_ctl;

   assign take      = HSEL && HTRANS[1] && HREADY;
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign wr_tx     = dp_write && (dp_addr == urcf_pkg::A_TXDATA);
   assign wr_ctl    = dp_write && (dp_addr == urcf_pkg::A_CONTROL);

   ////////////////////////////////////////////////////////////////////////////
   // Receive framer
   urcf_pkg::urcf_rx_state_type rx_state;
   urcf_pkg::urcf_rx_state_type next_rx_state;
   logic [7:0] rx_sr;
   logic [7:0] next_rx_sr;
   logic [2:0] rx_cnt;
   logic [2:0] next_rx_cnt;
   logic       rx_par;
   logic       next_rx_par;
   logic       rx_restart;
   logic       rx_half;
   logic       rx_done;
   logic       rx_stop_ok;
   logic [7:0] rx_byte;
   logic       rx_par_bad;
   logic       rx_good;

   urcf_bit_timer u_rx_timer (
      .clk     (CLK_SYS),
      .rst_n   (RST_N),
      .restart (rx_restart),
      .period  (bit_cyc),
      .half    (rx_half),
      .full    ()
   );

   always_comb begin
      next_rx_state = rx_state;
      next_rx_sr    = rx_sr;
      next_rx_cnt   = rx_cnt;
      next_rx_par   = rx_par;
      rx_restart    = 1'b0;
      rx_done       = 1'b0;
      rx_stop_ok    = 1'b0;
      case (rx_state)
         urcf_pkg::RX_IDLE: begin
            if (cfg_taken && !RXD) begin
               rx_restart    = 1'b1;
               next_rx_state = urcf_pkg::RX_START;
            end
         end
         urcf_pkg::RX_START: begin
            // A start bit gone high at mid-bit was only a glitch
            if (rx_half) begin
               next_rx_cnt   = 3'h0;
               next_rx_state = RXD ? urcf_pkg::RX_IDLE : urcf_pkg::RX_DATA;
            end
         end
         urcf_pkg::RX_DATA: begin
            if (rx_half) begin
               next_rx_sr  = {RXD, rx_sr[7:1]};
               next_rx_cnt = rx_cnt + 3'h1;
               if (rx_cnt == data_last) begin
                  next_rx_state = par_en ? urcf_pkg::RX_PAR
                                         : urcf_pkg::RX_STOP;
               end
            end
         end
         urcf_pkg::RX_PAR: begin
            if (rx_half) begin
               next_rx_par   = RXD;
               next_rx_state = urcf_pkg::RX_STOP;
            end
         end
         urcf_pkg::RX_STOP: begin
            // Only the first stop bit is checked, so 2-stop senders also fit
            if (rx_half) begin
               rx_done       = 1'b1;
               rx_stop_ok    = RXD;
               next_rx_state = urcf_pkg::RX_IDLE;
            end
         end
         default: next_rx_state = urcf_pkg::RX_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         rx_state <= urcf_pkg::RX_IDLE;
         rx_sr    <= 8'h00;
         rx_cnt   <= 3'h0;
         rx_par   <= 1'b0;
      end else begin
         rx_state <= next_rx_state;
         rx_sr    <= next_rx_sr;
         rx_cnt   <= next_rx_cnt;
         rx_par   <= next_rx_par;
      end
   end

   assign rx_byte    = len7 ? {1'b0, rx_sr[7:1]} : rx_sr;
   assign rx_par_bad = par_en && ((^rx_byte ^ rx_par) != par_odd);
   assign rx_good    = rx_done && rx_stop_ok && !rx_par_bad;

   ////////////////////////////////////////////////////////////////////////////
   // Receive buffer; bit 8 of each entry marks a CR delimiter
   logic [8:0]                 mem [urcf_pkg::BUF_DEPTH];
   logic [urcf_pkg::BUF_AW-1:0] wr_ptr;
   logic [urcf_pkg::BUF_AW-1:0] next_wr_ptr;
   logic [urcf_pkg::BUF_AW-1:0] rd_ptr;
   logic [urcf_pkg::BUF_AW-1:0] next_rd_ptr;
   logic [6:0] level;
   logic [6:0] next_level;
   logic       last_cr;
   logic       next_last_cr;
   logic       lf_drop;
   logic       push;
   logic       overrun;
   logic       test_done;
   logic       rx_avail;

   assign lf_drop  = last_cr && (rx_byte == urcf_pkg::CHAR_LF);
   assign push     = rx_good && !lf_drop && (level != urcf_pkg::LVL_FULL);
   assign overrun  = rx_good && !lf_drop && (level == urcf_pkg::LVL_FULL);
   // Held bytes stay buffered and unseen until self test is over
   assign rx_avail = test_done && (level != 7'h00);
   assign rd_pop   = take && !HWRITE && (HADDR == urcf_pkg::A_RXDATA) &&
                     rx_avail;

   always_comb begin
      next_wr_ptr  = push ? wr_ptr + 6'h01 : wr_ptr;
      next_rd_ptr  = rd_pop ? rd_ptr + 6'h01 : rd_ptr;
      next_last_cr = rx_good ? (rx_byte == urcf_pkg::CHAR_CR) : last_cr;
      case ({push, rd_pop})
         2'b10:   next_level = level + 7'h01;
         2'b01:   next_level = level - 7'h01;
         default: next_level = level;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         wr_ptr  <= 6'h00;
         rd_ptr  <= 6'h00;
         level   <= 7'h00;
         last_cr <= 1'b0;
      end else begin
         wr_ptr  <= next_wr_ptr;
         rd_ptr  <= next_rd_ptr;
         level   <= next_level;
         last_cr <= next_last_cr;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (push) begin
         mem[wr_ptr] <= {rx_byte == urcf_pkg::CHAR_CR, rx_byte};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit path: one holding byte in front of the shifter
   urcf_pkg::urcf_tx_state_type tx_state;
   urcf_pkg::urcf_tx_state_type next_tx_state;
   logic [7:0] tx_hold;
   logic [7:0] next_tx_hold;
   logic       tx_full;
   logic       next_tx_full;
   logic [7:0] tx_sr;
   logic [7:0] next_tx_sr;
   logic [2:0] tx_cnt;
   logic [2:0] next_tx_cnt;
   logic       tx_par;
   logic       next_tx_par;
   logic       tx_stop_n;
   logic       next_tx_stop_n;
   logic       txd_q;
   logic       next_txd;
   logic       tx_go;
   logic       tx_full_tick;
   logic [7:0] tx_load;

   urcf_bit_timer u_tx_timer (
      .clk     (CLK_SYS),
      .rst_n   (RST_N),
      .restart (tx_go),
      .period  (bit_cyc),
      .half    (),
      .full    (tx_full_tick)
   );

   // A character in flight always completes; CTS only gates the next start
   assign tx_go   = (tx_state == urcf_pkg::TX_IDLE) && tx_full && cfg_taken &&
                    (CTS || hs_off);
   assign tx_load = len7 ? {1'b0, tx_hold[6:0]} : tx_hold;
   assign TXD     = txd_q;

   always_comb begin
      next_tx_state  = tx_state;
      next_tx_hold   = tx_hold;
      next_tx_full   = tx_full;
      next_tx_sr     = tx_sr;
      next_tx_cnt    = tx_cnt;
      next_tx_par    = tx_par;
      next_tx_stop_n = tx_stop_n;
      next_txd       = txd_q;
      if (wr_tx && !tx_full) begin
         next_tx_hold = HWDATA[7:0];
         next_tx_full = 1'b1;
      end
      case (tx_state)
         urcf_pkg::TX_IDLE: begin
            next_txd = 1'b1;
            if (tx_go) begin
               next_tx_sr    = tx_load;
               next_tx_par   = ^tx_load ^ par_odd;
               next_tx_full  = 1'b0;
               next_txd      = 1'b0;
               next_tx_state = urcf_pkg::TX_START;
            end
         end
         urcf_pkg::TX_START: begin
            if (tx_full_tick) begin
               next_txd      = tx_sr[0];
               next_tx_sr    = {1'b0, tx_sr[7:1]};
               next_tx_cnt   = 3'h0;
               next_tx_state = urcf_pkg::TX_DATA;
            end
         end
         urcf_pkg::TX_DATA: begin
            if (tx_full_tick) begin
               if (tx_cnt == data_last) begin
                  next_txd       = par_en ? tx_par : 1'b1;
                  next_tx_stop_n = 1'b0;
                  next_tx_state  = par_en ? urcf_pkg::TX_PAR
                                          : urcf_pkg::TX_STOP;
               end else begin
                  next_txd    = tx_sr[0];
                  next_tx_sr  = {1'b0, tx_sr[7:1]};
                  next_tx_cnt = tx_cnt + 3'h1;
               end
            end
         end
         urcf_pkg::TX_PAR: begin
            if (tx_full_tick) begin
               next_txd      = 1'b1;
               next_tx_state = urcf_pkg::TX_STOP;
            end
         end
         urcf_pkg::TX_STOP: begin
            if (tx_full_tick) begin
               if (stop2 && !tx_stop_n) begin
                  next_tx_stop_n = 1'b1;
               end else begin
                  next_tx_state = urcf_pkg::TX_IDLE;
               end
            end
         end
         default: next_tx_state = urcf_pkg::TX_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         tx_state  <= urcf_pkg::TX_IDLE;
         tx_hold   <= 8'h00;
         tx_full   <= 1'b0;
         tx_sr     <= 8'h00;
         tx_cnt    <= 3'h0;
         tx_par    <= 1'b0;
         tx_stop_n <= 1'b0;
         txd_q     <= 1'b1;
      end else begin
         tx_state  <= next_tx_state;
         tx_hold   <= next_tx_hold;
         tx_full   <= next_tx_full;
         tx_sr     <= next_tx_sr;
         tx_cnt    <= next_tx_cnt;
         tx_par    <= next_tx_par;
         tx_stop_n <= next_tx_stop_n;
         txd_q     <= next_txd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flow control and sticky state; an event beats a same-cycle clear
   logic rts_q;
   logic next_rts;
   logic remote;
   logic next_remote;
   logic par_err;
   logic next_par_err;
   logic frm_err;
   logic next_frm_err;
   logic ovr_err;
   logic next_ovr_err;
   logic next_test_done;
   logic clr_err;

   assign clr_err = wr_ctl && HWDATA[urcf_pkg::CT_CLR_ERR];
   assign RTS     = rts_q;
   assign REMOTE  = remote;

   always_comb begin
      // Hysteresis between the two levels keeps RTS from chattering
      if (hs_off) begin
         next_rts = 1'b1;
      end else if (level > urcf_pkg::LVL_HIGH) begin
         next_rts = 1'b0;
      end else if (level < urcf_pkg::LVL_LOW) begin
         next_rts = 1'b1;
      end else begin
         next_rts = rts_q;
      end
      next_remote    = (remote && !(wr_ctl && HWDATA[urcf_pkg::CT_LOCAL])) ||
                       rx_done || tx_go;
      next_par_err   = (par_err && !clr_err) || (rx_done && rx_par_bad);
      next_frm_err   = (frm_err && !clr_err) || (rx_done && !rx_stop_ok);
      next_ovr_err   = (ovr_err && !clr_err) || overrun;
      next_test_done = test_done ||
                       (wr_ctl && HWDATA[urcf_pkg::CT_TEST_DONE]);
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         rts_q     <= 1'b1;
         remote    <= 1'b0;
         par_err   <= 1'b0;
         frm_err   <= 1'b0;
         ovr_err   <= 1'b0;
         test_done <= 1'b0;
      end else begin
         rts_q     <= next_rts;
         remote    <= next_remote;
         par_err   <= next_par_err;
         frm_err   <= next_frm_err;
         ovr_err   <= next_ovr_err;
         test_done <= next_test_done;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux and bus phase registers
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (HADDR)
         urcf_pkg::A_RXDATA: begin
            rd_mux[urcf_pkg::RXD_VALID_BIT] = rx_avail;
            rd_mux[urcf_pkg::RXD_DELIM_BIT] = rx_avail && mem[rd_ptr][8];
            rd_mux[7:0] = rx_avail ? mem[rd_ptr][7:0] : 8'h00;
         end
         urcf_pkg::A_STATUS: begin
            rd_mux[urcf_pkg::ST_TX_FULL]   = tx_full;
            rd_mux[urcf_pkg::ST_RX_AVAIL]  = rx_avail;
            rd_mux[urcf_pkg::ST_RTS]       = rts_q;
            rd_mux[urcf_pkg::ST_CTS]       = CTS;
            rd_mux[urcf_pkg::ST_REMOTE]    = remote;
            rd_mux[urcf_pkg::ST_PAR_ERR]   = par_err;
            rd_mux[urcf_pkg::ST_FRM_ERR]   = frm_err;
            rd_mux[urcf_pkg::ST_OVR_ERR]   = ovr_err;
            rd_mux[urcf_pkg::ST_TEST_DONE] = test_done;
            rd_mux[urcf_pkg::ST_TX_BUSY]   = tx_state != urcf_pkg::TX_IDLE;
            rd_mux[urcf_pkg::ST_CFG_LSB +: 8] = cfg;
            rd_mux[urcf_pkg::ST_LVL_LSB +: 7] = level;
         end
         urcf_pkg::A_CONTROL: rd_mux[urcf_pkg::CT_TEST_DONE] = test_done;
         default:             rd_mux = 32'h0000_0000;
      endcase
      next_dp_write = take && HWRITE;
      next_dp_addr  = take ? HADDR : dp_addr;
      next_hrdata   = (take && !HWRITE) ? rd_mux : HRDATA;
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         dp_write <= 1'b0;
         dp_addr  <= 32'h0000_0000;
         HRDATA   <= 32'h0000_0000;
      end else begin
         dp_write <= next_dp_write;
         dp_addr  <= next_dp_addr;
         HRDATA   <= next_hrdata;
      end
   end

endmodule
`default_nettype wire

/* File: test/urcf_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module urcf_assertions #(
   parameter logic [15:0] BIT_CYC_9600 = 16'h0010
) (
   input wire logic        CLK_SYS,
   input wire logic        RST_N,
   input wire logic        HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0]  HTRANS,
   input wire logic        HWRITE,
   input wire logic        RXD,
   input wire logic        TXD,
   input wire logic        RTS,
   input wire logic        CTS,
   input wire logic        REMOTE
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   wire logic   rd = HSEL && HTRANS[1] && !HWRITE && HADDR == 32'h4;
   wire logic   wr = HSEL && HTRANS[1] && HWRITE && HADDR == 32'hc;
   logic [15:0] run;
   logic [8:0]  stall;
   logic [3:0]  rd_seen;
   logic [3:0]  wr_seen;
   logic        prv;
   // Run starts saturated, so a short idle after reset is not a short bit
   always_ff @(posedge CLK_SYS) begin
      prv <= TXD;
      rd_seen <= {rd_seen[2:0], rd};
      wr_seen <= {wr_seen[2:0], wr};
      if (!RST_N) run <= 16'hffff;
      else if (TXD != prv) run <= 16'h1;
      else if (run != 16'hffff) run <= run + 16'h1;
      if (!RST_N || CTS || !TXD) stall <= 9'h0;
      else if (stall != 9'h1ff) stall <= stall + 9'h1;
   end
   ////////////////////////////////////////////////////////////////////////////
   tx_fall_a: assert property ($fell(TXD) |-> run >= BIT_CYC_9600)
      else $error("serial line fell early");
   tx_rise_a: assert property (
      $rose(TXD) |-> run % BIT_CYC_9600 == 16'h0)
      else $error("low run not whole bits");
   reset_idle_a: assert property (
      $rose(RST_N) |-> (TXD && RTS && !REMOTE)[*2])
      else $error("lines not idle after reset");
   rts_fall_a: assert property ($fell(RTS) |-> RXD)
      else $error("RTS fell outside a stop bit");
   rts_rise_a: assert property ($rose(RTS) |-> |rd_seen)
      else $error("RTS rose without a read");
   cts_stall_a: assert property (
      stall > 13 * BIT_CYC_9600 |-> TXD)
      else $error("sent while CTS low");
   remote_rise_a: assert property (
      $rose(REMOTE) |-> RXD or ##[0:3] !TXD)
      else $error("remote without traffic");
   remote_clr_a: assert property ($fell(REMOTE) |-> |wr_seen)
      else $error("remote cleared without key");
endmodule
bind urcf_top urcf_assertions #(.BIT_CYC_9600(BIT_CYC_9600))
   urcf_assertions_inst (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .HSEL(HSEL),
   .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .RXD(RXD), .TXD(TXD),
   .RTS(RTS), .CTS(CTS), .REMOTE(REMOTE));
`default_nettype wire

/* File: test/urcf_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none
module urcf_ctrl_model #(
   parameter int BIT_CYC = 16
) (
   input  wire logic clk,
   input  wire logic rts,
   input  wire logic txd,
   output logic      rxd
);
   initial rxd = 1'b1;
   // Sends 8N1 LSB first; a frame once started is always finished
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      while (rts !== 1'b1) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         rxd <= f[i];
         repeat (BIT_CYC) @(posedge clk);
      end
   endtask
   // Twelve mid-bit samples from the start bit on
   task automatic recv(output logic [11:0] s);
      while (txd !== 1'b0) @(posedge clk);
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 12; i++) begin
         s[i] = txd;
         repeat (BIT_CYC) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

/* File: test/urcf_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module urcf_top_tb;
   localparam logic [15:0] BC = 16'h0010;
   localparam logic [31:0] RXA = urcf_pkg::A_RXDATA;
   localparam logic [31:0] CTA = urcf_pkg::A_CONTROL;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [7:0]  cfg_sw = 8'h0;
   logic        cts = 1'b1;
   logic [31:0] hrdata, q;
   logic [11:0] s;
   logic        hready, hresp, txd, rts, rxd, remote;
   int          bad_count = 0;
   int          num_checks = 0;
   int          cyc = 0;
   urcf_top #(.BIT_CYC_2400(BC), .BIT_CYC_4800(BC), .BIT_CYC_9600(BC),
      .BIT_CYC_19200(BC)) urcf_top_inst (.CLK_SYS(clk), .RST_N(rst_n),
      .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
      .HREADYOUT(hready), .HRESP(hresp), .CFG_SW(cfg_sw), .RXD(rxd), .TXD(txd),
      .RTS(rts), .CTS(cts), .REMOTE(remote));
   urcf_ctrl_model #(.BIT_CYC(int'(BC))) ctrl_inst (.clk(clk), .rts(rts),
      .txd(txd), .rxd(rxd));
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, e);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %0t got %h", $time, g);
      end
   endtask
   task automatic xfer(input logic w, input logic [31:0] a, d);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic do_reset(input logic [7:0] sw);
      rst_n <= 1'b0;
      cfg_sw <= sw;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_rx_hold();
      ctrl_inst.send(8'h41);
      ctrl_inst.send(urcf_pkg::CHAR_CR);
      ctrl_inst.send(urcf_pkg::CHAR_LF);
      xfer(1'b1, 32'h1c, 32'h1);
      xfer(1'b0, RXA, 32'h0);
      chk(q, 32'h0);
      chk({31'h0, remote}, 32'h1);
      xfer(1'b1, CTA, 32'h1);
      xfer(1'b0, RXA, 32'h0);
      chk(q, 32'h141);
      xfer(1'b0, RXA, 32'h0);
      chk(q, 32'h30d);
      xfer(1'b0, RXA, 32'h0);
      chk(q, 32'h0);
      xfer(1'b1, CTA, 32'h2);
      repeat (2) @(posedge clk);
      chk({31'h0, remote}, 32'h0);
   endtask
   task automatic t_rts();
      for (int i = 0; i < 55; i++) begin
         ctrl_inst.send(8'(8'h20 + i));
         chk({31'h0, rts}, {31'h0, i < 54});
      end
      for (int i = 0; i < 55; i++) begin
         xfer(1'b0, RXA, 32'h0);
         chk(q, 32'h120 + 32'(i));
         repeat (2) @(posedge clk);
         chk({31'h0, rts}, {31'h0, i > 38});
      end
   endtask
   // Switches moved in mid-run must leave 9600 8N1 with handshake in force
   task automatic t_tx_cts();
      cfg_sw <= 8'hff;
      cts <= 1'b0;
      xfer(1'b1, urcf_pkg::A_TXDATA, 32'h55);
      xfer(1'b1, urcf_pkg::A_TXDATA, 32'haa);
      repeat (20 * BC) @(posedge clk);
      chk({31'h0, txd}, 32'h1);
      cts <= 1'b1;
      ctrl_inst.recv(s);
      chk({20'h0, s}, {20'h0, 3'h7, 8'h55, 1'b0});
   endtask
   // A queued second char shows both stop bits before its start bit
   task automatic t_format();
      do_reset(8'h3c);
      xfer(1'b0, urcf_pkg::A_STATUS, 32'h0);
      chk(q, 32'h003c_000c);
      chk({31'h0, hresp}, 32'h0);
      xfer(1'b1, urcf_pkg::A_TXDATA, 32'h34);
      xfer(1'b1, urcf_pkg::A_TXDATA, 32'h34);
      ctrl_inst.recv(s);
      chk({20'h0, s}, {20'h0, 4'h6, 7'h34, 1'b0});
   endtask
   task automatic tally_and_finish();
      if (bad_count == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      do_reset(8'h00);
      t_rx_hold();
      t_rts();
      t_tx_cts();
      t_format();
      tally_and_finish();
   end
endmodule
`default_nettype wire
